// ===== crhi_map.svh
// Constants for the reset, halt and interrupt input control block
`ifndef CRHI_MAP_SVH
`define CRHI_MAP_SVH

// ----------------------------------------------------------------
// Priority levels and vectors
// ----------------------------------------------------------------
`define CRHI_IPL_TIMER       5'h10
`define CRHI_IPL_SHARED      5'h0E
`define CRHI_VEC_TIMER       16'h00C0
`define CRHI_VEC_NONE        16'h0000
`define CRHI_IPL_NONE        5'h00

// ----------------------------------------------------------------
// Halt write cycle and restart
// ----------------------------------------------------------------
`define CRHI_CS_NONFPU_CMD   2'h2
`define CRHI_CS_IDLE         2'h0
`define CRHI_HALT_DATA       6'h3F
`define CRHI_DATA_IDLE       6'h00
`define CRHI_RESTART_HALT    3'h2
`define CRHI_RESTART_NONE    3'h0

// ----------------------------------------------------------------
// Reset levels
// ----------------------------------------------------------------
`define CRHI_LINE_IDLE       1'b1
`define CRHI_FLAG_CLEAR      1'b0

`endif

// ===== crhi_pkg.sv
// Types and shared decode for the reset, halt and interrupt input control block
`default_nettype none

package crhi_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CRHI_ST_RUN     = 4'b0001,
    CRHI_ST_HALT_WR = 4'b0010,
    CRHI_ST_RESTART = 4'b0100,
    CRHI_ST_IACK    = 4'b1000
  } crhi_state_t;

  typedef logic [4:0]  crhi_ipl_t;
  typedef logic [15:0] crhi_vec_t;

  // ----------------------------------------------------------------
  // A request wins only above the running priority level
  // ----------------------------------------------------------------
  function automatic logic crhi_wins(input logic req, input crhi_ipl_t lvl,
                                     input crhi_ipl_t cur);
    crhi_wins = req && (lvl > cur);
  endfunction : crhi_wins

endpackage : crhi_pkg

`default_nettype wire

// ===== crhi_sync.sv
// Two-stage input synchroniser with registered falling-edge detect
`timescale 1ns/100ps
`default_nettype none

`include "crhi_map.svh"

module crhi_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic clr_n,
  // Raw line and synchronised results
  input  wire logic line_n,
  output logic      level_n,
  output logic      fall
);

  logic meta_r;
  logic meta_nxt;
  logic stage_r;
  logic stage_nxt;
  logic prev_r;
  logic prev_nxt;
  logic fall_r;
  logic fall_nxt;

  // Only stage_r looks at meta_r
  always_comb begin
    meta_nxt  = line_n;
    stage_nxt = meta_r;
    prev_nxt  = stage_r;
    fall_nxt  = prev_r & ~stage_r;
    if (!clr_n) begin
      meta_nxt  = `CRHI_LINE_IDLE;
      stage_nxt = `CRHI_LINE_IDLE;
      prev_nxt  = `CRHI_LINE_IDLE;
      fall_nxt  = `CRHI_FLAG_CLEAR;
    end
  end

  always_ff @(posedge clk) begin
    meta_r  <= meta_nxt;
    stage_r <= stage_nxt;
    prev_r  <= prev_nxt;
    fall_r  <= fall_nxt;
  end

  assign level_n = stage_r;
  assign fall    = fall_r;

endmodule : crhi_sync

`default_nettype wire

// ===== crhi_ctrl.sv
// Reset, halt request and interrupt request input control of the processor
// What this block does
// - Asserted reset input returns all internal state to power-up condition.
// - Halt request hands control to console firmware, not the running program.
// - After halt, finish current instruction, then one external write cycle.
// - Halt write cycle drives status pair 10 and low six data lines ones.
// - After that write, start restart sequence with restart code 2.
// - Halt input is edge-triggered, sampled every cycle, synchronised first.
// - Timer interrupt is taken at level 16, vector offset C0 hex.
// - Timer interrupt runs no interrupt acknowledge bus cycle.
// - Timer input is edge-triggered, sampled every cycle, synchronised.
// - Shared device interrupt is serviced at priority level 14.
// - Taking a shared device interrupt runs an interrupt acknowledge cycle.
// - Shared device input is level-sensitive, sampled every cycle, synchronised.
// - Write line low with status pair high-low marks non-FPU write command.
`timescale 1ns/100ps
`default_nettype none

`include "crhi_map.svh"

module crhi_ctrl (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Pins from the support cell, all active low
  input  wire logic           cpu_reset_in_n,
  input  wire logic           halt_in_n,
  input  wire logic           interval_tick_irq_n,
  input  wire logic           shared_device_irq_n,
  input  wire logic           spare_irq_a_n,
  input  wire logic           spare_irq_b_n,
  input  wire logic           spare_irq_c_n,
  input  wire logic           supply_loss_in_n,
  // Execution unit side
  input  wire logic           instr_boundary,
  input  wire crhi_pkg::crhi_ipl_t cur_ipl,
  output logic                take_valid,
  output crhi_pkg::crhi_ipl_t take_ipl,
  output crhi_pkg::crhi_vec_t take_vector,
  output logic                console_enter,
  output logic                restart_valid,
  output logic [2:0]          restart_code,
  output logic                busy,
  output logic                spare_line_active,
  // External processor write cycle
  output logic                ext_wr_req,
  input  wire logic           ext_wr_done,
  output logic                ext_write_n,
  output logic [1:0]          cycle_status_pair,
  output logic [5:0]          addr_data_low_six,
  // Interrupt acknowledge cycle
  output logic                iack_req,
  input  wire logic           iack_done,
  input  wire crhi_pkg::crhi_vec_t iack_vector
);

  import crhi_pkg::*;

  // ----------------------------------------------------------------
  // Reset and input synchronisation
  // ----------------------------------------------------------------
  logic clr_n;
  logic halt_fall;
  logic tick_fall;
  logic shared_lvl_n;

  assign clr_n = rst_n & cpu_reset_in_n;

  crhi_sync u_halt_sync (
    .clk     (clk),
    .clr_n   (clr_n),
    .line_n  (halt_in_n),
    .level_n (),
    .fall    (halt_fall)
  );

  crhi_sync u_tick_sync (
    .clk     (clk),
    .clr_n   (clr_n),
    .line_n  (interval_tick_irq_n),
    .level_n (),
    .fall    (tick_fall)
  );

  crhi_sync u_shared_sync (
    .clk     (clk),
    .clr_n   (clr_n),
    .line_n  (shared_device_irq_n),
    .level_n (shared_lvl_n),
    .fall    ()
  );

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  crhi_state_t state_r;
  crhi_state_t state_nxt;
  logic        halt_pend_r;
  logic        halt_pend_nxt;
  logic        tick_pend_r;
  logic        tick_pend_nxt;
  logic        halt_clr;
  logic        tick_clr;
  logic        take_valid_r;
  logic        take_valid_nxt;
  crhi_ipl_t   take_ipl_r;
  crhi_ipl_t   take_ipl_nxt;
  crhi_vec_t   take_vector_r;
  crhi_vec_t   take_vector_nxt;
  logic        console_r;
  logic        console_nxt;
  logic        restart_valid_r;
  logic        restart_valid_nxt;
  logic [2:0]  restart_code_r;
  logic [2:0]  restart_code_nxt;
  logic [1:0]  status_r;
  logic [1:0]  status_nxt;
  logic [5:0]  data_r;
  logic [5:0]  data_nxt;
  logic        spare_r;
  logic        spare_nxt;
  logic        tick_wins;
  logic        shared_wins;

  assign shared_wins = crhi_wins(~shared_lvl_n, `CRHI_IPL_SHARED, cur_ipl);
  assign tick_wins   = crhi_wins(tick_pend_r, `CRHI_IPL_TIMER, cur_ipl);

  always_comb begin
    state_nxt         = state_r;
    halt_clr          = 1'b0;
    tick_clr          = 1'b0;
    take_valid_nxt    = 1'b0;
    take_ipl_nxt      = take_ipl_r;
    take_vector_nxt   = take_vector_r;
    console_nxt       = 1'b0;
    restart_valid_nxt = 1'b0;
    restart_code_nxt  = restart_code_r;
    status_nxt        = status_r;
    data_nxt          = data_r;
    // Unused lines are only reported; a low one means a board fault
    spare_nxt = ~(spare_irq_a_n & spare_irq_b_n & spare_irq_c_n & supply_loss_in_n);
    case (state_r)
      CRHI_ST_RUN: begin
        if (instr_boundary) begin
          if (halt_pend_r) begin
            halt_clr  = 1'b1;
            state_nxt = CRHI_ST_HALT_WR;
            status_nxt = `CRHI_CS_NONFPU_CMD;
            data_nxt   = `CRHI_HALT_DATA;
          end else if (tick_wins) begin
            tick_clr        = 1'b1;
            take_valid_nxt  = 1'b1;
            take_ipl_nxt    = `CRHI_IPL_TIMER;
            take_vector_nxt = `CRHI_VEC_TIMER;
          end else if (shared_wins) begin
            state_nxt = CRHI_ST_IACK;
          end
        end
      end
      CRHI_ST_HALT_WR: begin
        if (ext_wr_done) begin
          state_nxt  = CRHI_ST_RESTART;
          status_nxt = `CRHI_CS_IDLE;
          data_nxt   = `CRHI_DATA_IDLE;
        end
      end
      CRHI_ST_RESTART: begin
        restart_valid_nxt = 1'b1;
        restart_code_nxt  = `CRHI_RESTART_HALT;
        console_nxt       = 1'b1;
        state_nxt         = CRHI_ST_RUN;
      end
      CRHI_ST_IACK: begin
        if (iack_done) begin
          take_valid_nxt  = 1'b1;
          take_ipl_nxt    = `CRHI_IPL_SHARED;
          take_vector_nxt = iack_vector;
          state_nxt       = CRHI_ST_RUN;
        end
      end
      default: begin
        state_nxt = CRHI_ST_RUN;
      end
    endcase
    halt_pend_nxt = halt_fall | (halt_pend_r & ~halt_clr);
    tick_pend_nxt = tick_fall | (tick_pend_r & ~tick_clr);
    if (!clr_n) begin
      state_nxt         = CRHI_ST_RUN;
      halt_pend_nxt     = `CRHI_FLAG_CLEAR;
      tick_pend_nxt     = `CRHI_FLAG_CLEAR;
      take_valid_nxt    = 1'b0;
      take_ipl_nxt      = `CRHI_IPL_NONE;
      take_vector_nxt   = `CRHI_VEC_NONE;
      console_nxt       = 1'b0;
      restart_valid_nxt = 1'b0;
      restart_code_nxt  = `CRHI_RESTART_NONE;
      status_nxt        = `CRHI_CS_IDLE;
      data_nxt          = `CRHI_DATA_IDLE;
      spare_nxt         = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_r         <= state_nxt;
    halt_pend_r     <= halt_pend_nxt;
    tick_pend_r     <= tick_pend_nxt;
    take_valid_r    <= take_valid_nxt;
    take_ipl_r      <= take_ipl_nxt;
    take_vector_r   <= take_vector_nxt;
    console_r       <= console_nxt;
    restart_valid_r <= restart_valid_nxt;
    restart_code_r  <= restart_code_nxt;
    status_r        <= status_nxt;
    data_r          <= data_nxt;
    spare_r         <= spare_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign take_valid        = take_valid_r;
  assign take_ipl          = take_ipl_r;
  assign take_vector       = take_vector_r;
  assign console_enter     = console_r;
  assign restart_valid     = restart_valid_r;
  assign restart_code      = restart_code_r;
  assign cycle_status_pair = status_r;
  assign addr_data_low_six = data_r;
  assign spare_line_active = spare_r;
  assign ext_wr_req        = (state_r == CRHI_ST_HALT_WR);
  assign ext_write_n       = ~(state_r == CRHI_ST_HALT_WR);
  assign iack_req          = (state_r == CRHI_ST_IACK);
  // Execution unit must hold off the next instruction while not running
  assign busy              = (state_r != CRHI_ST_RUN);

endmodule : crhi_ctrl

`default_nettype wire

// ===== crhi_ctrl_asserts.sv
// Concurrent checks on the reset, halt and interrupt input control ports
`timescale 1ns/100ps
`default_nettype none

module crhi_ctrl_asserts import crhi_pkg::*; (
  // Clock and resets
  input wire logic      clk,
  input wire logic      rst_n,
  input wire logic      cpu_reset_in_n,
  // Execution unit side
  input wire logic      instr_boundary,
  input wire logic      take_valid,
  input wire crhi_ipl_t take_ipl,
  input wire crhi_vec_t take_vector,
  input wire logic      console_enter,
  input wire logic      restart_valid,
  input wire logic [2:0] restart_code,
  input wire logic      busy,
  // Bus cycles
  input wire logic      ext_wr_req,
  input wire logic      ext_wr_done,
  input wire logic      ext_write_n,
  input wire logic [1:0] cycle_status_pair,
  input wire logic [5:0] addr_data_low_six,
  input wire logic      iack_req,
  input wire logic      iack_done,
  input wire crhi_vec_t iack_vector
);
  default clocking cb @(posedge clk); endclocking
  // Either reset pin clears the sequencer
  default disable iff (!rst_n || !cpu_reset_in_n);

  a_halt_wr_pins: assert property (ext_wr_req |->
    cycle_status_pair == 2'h2 && addr_data_low_six == 6'h3F) else $error("halt write pins");
  a_write_line_low: assert property (ext_wr_req |-> !ext_write_n && busy)
    else $error("write line not low");
  a_halt_at_bound: assert property ($rose(ext_wr_req) |-> $past(instr_boundary))
    else $error("halt write off boundary");
  a_restart_code: assert property (ext_wr_req && ext_wr_done |=>
    !ext_wr_req ##1 restart_valid && restart_code == 3'h2) else $error("no restart");
  a_console_entry: assert property (console_enter |->
    restart_valid && restart_code == 3'h2) else $error("console entry");
  a_timer_vector: assert property (take_valid && take_ipl == 5'h10 |->
    take_vector == 16'h00C0) else $error("timer vector");
  a_timer_no_ack: assert property (take_valid && take_ipl == 5'h10 |->
    !$past(iack_req)) else $error("timer acknowledged");
  a_shared_ack: assert property (take_valid && take_ipl == 5'h0E |->
    $past(iack_req && iack_done) && take_vector == $past(iack_vector)) else $error("no iack");
  a_ack_at_bound: assert property ($rose(iack_req) |-> $past(instr_boundary))
    else $error("iack off boundary");
  a_reset_clears: assert property (disable iff (1'b0) !(rst_n && cpu_reset_in_n) |=>
    !take_valid && !restart_valid && !busy && take_ipl == 5'h00) else $error("reset");

  c_restart: cover property (restart_valid);
  c_timer: cover property (take_valid && take_ipl == 5'h10);
  c_iack: cover property (iack_req && iack_done);
endmodule : crhi_ctrl_asserts

bind crhi_ctrl crhi_ctrl_asserts u_chk (.clk, .rst_n, .cpu_reset_in_n, .instr_boundary,
  .take_valid, .take_ipl, .take_vector, .console_enter, .restart_valid, .restart_code,
  .busy, .ext_wr_req, .ext_wr_done, .ext_write_n, .cycle_status_pair,
  .addr_data_low_six, .iack_req, .iack_done, .iack_vector);

`default_nettype wire

// ===== crhi_cell_model.sv
// Support cell model driving reset and interrupt pins
`timescale 1ns/100ps
`default_nettype none

module crhi_cell_model (
  // Clock and requests
  input  wire logic       clk,
  input  wire logic       reset_req,
  input  wire logic       tick_req,
  input  wire logic [1:0] dev_req,
  // Pins
  output logic            cpu_reset_in_n,
  output logic            interval_tick_irq_n,
  output logic            shared_device_irq_n,
  output logic            spare_n
);
  initial begin
    cpu_reset_in_n      = 1'b1;
    interval_tick_irq_n = 1'b1;
    shared_device_irq_n = 1'b1;
  end
  assign spare_n = 1'b1;
  // Pins move just after the edge so the sampler never races them
  always @(posedge clk) begin
    cpu_reset_in_n <= #1 !reset_req;
    interval_tick_irq_n <= #1 !tick_req;
    shared_device_irq_n <= #1 !(|dev_req);
  end
endmodule : crhi_cell_model

`default_nettype wire

// ===== test_crhi_ctrl.sv
// Self-checking testbench for the reset, halt and interrupt input block
`timescale 1ns/100ps
`default_nettype none

module test_crhi_ctrl;
  import crhi_pkg::*;
  logic clk, rst_n, halt_in_n, instr_boundary, ext_wr_done, iack_done;
  logic reset_req, tick_req, cpu_reset_in_n, tick_n, dev_n, spare_n, spare_active;
  logic take_valid, console_enter, restart_valid, busy, ext_wr_req, ext_write_n, iack_req;
  logic [1:0] dev_req, cycle_status_pair;
  logic [2:0] restart_code;
  logic [5:0] addr_data_low_six;
  crhi_ipl_t  cur_ipl, take_ipl;
  crhi_vec_t  take_vector, iack_vector;
  int         bad_count, n_compared, i;

  crhi_cell_model u_cell (.clk(clk), .reset_req(reset_req), .tick_req(tick_req),
    .dev_req(dev_req), .cpu_reset_in_n(cpu_reset_in_n), .interval_tick_irq_n(tick_n),
    .shared_device_irq_n(dev_n), .spare_n(spare_n));
  crhi_ctrl u_dut (.clk(clk), .rst_n(rst_n), .cpu_reset_in_n(cpu_reset_in_n),
    .halt_in_n(halt_in_n), .interval_tick_irq_n(tick_n), .shared_device_irq_n(dev_n),
    .spare_irq_a_n(spare_n), .spare_irq_b_n(spare_n), .spare_irq_c_n(spare_n),
    .supply_loss_in_n(spare_n), .instr_boundary(instr_boundary), .cur_ipl(cur_ipl),
    .take_valid(take_valid), .take_ipl(take_ipl), .take_vector(take_vector),
    .console_enter(console_enter), .restart_valid(restart_valid),
    .restart_code(restart_code), .busy(busy), .spare_line_active(spare_active),
    .ext_wr_req(ext_wr_req), .ext_wr_done(ext_wr_done), .ext_write_n(ext_write_n),
    .cycle_status_pair(cycle_status_pair), .addr_data_low_six(addr_data_low_six),
    .iack_req(iack_req), .iack_done(iack_done), .iack_vector(iack_vector));

  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Boundary pulse, then the first answer cycle is visible
  task automatic bound();
    instr_boundary = 1'b1;
    step();
    instr_boundary = 1'b0;
  endtask : bound

  task automatic finish_write();
    step();
    ext_wr_done = 1'b1;
    step();
    ext_wr_done = 1'b0;
    for (i = 0; i < 10 && restart_valid !== 1'b1; i++) step();
    // Restart code holds from an earlier halt, so the pulse itself is checked
    chk(restart_valid, 16'h0001);
    chk(restart_code, 16'h0002);
    chk(console_enter, 16'h0001);
    step();
  endtask : finish_write

  task automatic t_halt();
    chk(spare_active, 16'h0000);
    halt_in_n = 1'b0;
    repeat (6) step();
    chk(busy, 16'h0000);
    bound();
    halt_in_n = 1'b1;
    chk({ext_wr_req, ext_write_n, cycle_status_pair}, 16'h000A);
    chk(addr_data_low_six, 16'h003F);
    finish_write();
  endtask : t_halt

  task automatic t_halt_first();
    halt_in_n = 1'b0;
    tick_req = 1'b1;
    step();
    tick_req = 1'b0;
    repeat (6) step();
    bound();
    halt_in_n = 1'b1;
    chk({take_valid, ext_wr_req}, 16'h0001);
    finish_write();
    bound();
    chk({take_valid, iack_req, take_ipl}, 16'h0050);
    chk(take_vector, 16'h00C0);
  endtask : t_halt_first

  task automatic t_shared();
    cur_ipl = 5'h0E;
    dev_req = 2'b10;
    repeat (5) step();
    bound();
    chk(iack_req, 16'h0000);
    cur_ipl = 5'h00;
    // Let one edge pass so the boundary strobe is not raised where it was just lowered
    step();
    bound();
    chk(iack_req, 16'h0001);
    iack_vector = 16'h0123;
    iack_done = 1'b1;
    step();
    iack_done = 1'b0;
    dev_req = 2'b00;
    chk({take_valid, take_ipl}, 16'h002E);
    chk(take_vector, 16'h0123);
  endtask : t_shared

  task automatic t_reset();
    reset_req = 1'b1;
    repeat (3) step();
    chk({take_ipl, restart_code}, 16'h0000);
    chk(take_vector, 16'h0000);
    reset_req = 1'b0;
    repeat (2) step();
  endtask : t_reset

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {rst_n, instr_boundary, ext_wr_done, iack_done, reset_req, tick_req} = '0;
    {halt_in_n, dev_req, cur_ipl, iack_vector} = {1'b1, 23'h00_0000};
    repeat (8) step();
    rst_n = 1'b1;
    step();
    t_halt();
    t_halt_first();
    t_shared();
    t_reset();
    tally_and_finish();
  end
endmodule : test_crhi_ctrl

`default_nettype wire
